// ---- hw/scp_params.svh ----
// constants for the serial command port: framing, timing, characters, buffer sizes
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
`define SCP_CLK_HZ 20000000
`define SCP_BAUD 115200
// cycles per bit, rounded to nearest: 20e6/115200 = 173.6
`define SCP_BIT_CYC ((`SCP_CLK_HZ + (`SCP_BAUD / 2)) / `SCP_BAUD)
`define SCP_DATA_BITS 8
`define SCP_STOP_BITS 1
`define SCP_CH_CR 8'h0D
`define SCP_CH_LF 8'h0A
`define SCP_CH_SP 8'h20
`define SCP_BUF_DEPTH 32
`define SCP_BUF_AW 5
`define SCP_OUT_DEPTH 32
`define SCP_OUT_AW 5
`endif

// ---- hw/scp_pkg.sv ----
// types shared by the serial command port
`default_nettype none
package scp_pkg;
	typedef enum logic [2:0] {
		SCP_IDLE = 3'b000,
		SCP_RECV = 3'b001,
		SCP_EXEC = 3'b010,
		SCP_SEND = 3'b011,
		SCP_TERM = 3'b100
	} scp_state_type;
	typedef enum logic [1:0] {
		SCP_UX_IDLE = 2'b00,
		SCP_UX_START = 2'b01,
		SCP_UX_DATA = 2'b10,
		SCP_UX_STOP = 2'b11
	} scp_uart_type;
endpackage : scp_pkg
`default_nettype wire

// ---- hw/scp_serial_command_port.sv ----
// serial command port: uart, terminator detection, command/reply exchange
//
// Functional notes
// R1: link runs 115200 baud, 8 data bits, no parity, one stop bit.
// R2: only transmit, receive and common lines; no flow control at all.
// R3: device is DCE: transmits on the line the terminal receives on.
// R4: traffic is ASCII; keyword letters are folded to upper case.
// R5: every reply ends with carriage return then line feed.
// R6: CR, LF, CR LF or LF CR all end a command.
// R7: exactly one reply per terminated command, once processing finishes.
// R8: host waits for a full reply before sending the next command.
// R9: serial commands and replies share one buffer.
// R10: serial and network ports run together, each with its own output buffer.
// R11: host should normally use one interface at a time.
// R12: network session on TCP port 7180 takes the same command set.
// R13: full or shortened keywords are the same command; left to the processor.
// R14: commands without a value get the CR LF pair alone.
// R15: invalid commands get an error code, terminated like any reply.
// R16: second character of a two-character terminator is not a new command.
`default_nettype none
`include "scp_params.svh"
module scp_serial_command_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic rx_line,
	output logic tx_line,
	output logic cmd_valid,
	output logic [`SCP_BUF_AW:0] cmd_len,
	input wire logic [`SCP_BUF_AW-1:0] proc_addr,
	output logic [7:0] proc_rdata,
	input wire logic proc_we,
	input wire logic [7:0] proc_wdata,
	input wire logic proc_done,
	input wire logic [`SCP_BUF_AW:0] reply_len,
	input wire logic proc_error,
	input wire logic [7:0] err_code,
	output logic busy,
	input wire logic net_wr_valid,
	input wire logic [7:0] net_wr_data,
	input wire logic net_rd_ready,
	output logic net_rd_valid,
	output logic [7:0] net_rd_data
);
	localparam int BITC = `SCP_BIT_CYC;
	localparam logic [7:0] HALF = 8'(BITC / 2); // mid-bit sample point
	localparam logic [7:0] FULL = 8'(BITC - 1);
	// upper-case fold of an ascii letter
	function automatic logic [7:0] scp_upper(input logic [7:0] c);
		scp_upper = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
	endfunction : scp_upper
	// true for either terminator character
	function automatic logic scp_is_term(input logic [7:0] c);
		scp_is_term = (c == `SCP_CH_CR) || (c == `SCP_CH_LF);
	endfunction : scp_is_term
	// ==========================================================
	// input synchroniser
	logic s1_r, s2_r, s3_r, rxd_r, rxd_nxt;
	always_comb begin
		rxd_nxt = (s2_r == s3_r) ? s3_r : rxd_r; // change once two stages agree
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			rxd_r <= 1'b1;
		end else begin
			s1_r <= rx_line;
			s2_r <= s1_r;
			s3_r <= s2_r;
			rxd_r <= rxd_nxt;
		end
	end
	// ==========================================================
	// receiver: 8N1, no parity, no handshake lines
	scp_pkg::scp_uart_type rs_r, rs_nxt;
	logic [7:0] rcnt_r, rcnt_nxt, rsh_r, rsh_nxt;
	logic [2:0] rbit_r, rbit_nxt;
	logic rstb_r, rstb_nxt;
	always_comb begin
		rs_nxt = rs_r;
		rcnt_nxt = rcnt_r + 8'h01;
		rsh_nxt = rsh_r;
		rbit_nxt = rbit_r;
		rstb_nxt = 1'b0;
		case (rs_r)
			scp_pkg::SCP_UX_IDLE: begin
				rcnt_nxt = 8'h00;
				if (!rxd_r) rs_nxt = scp_pkg::SCP_UX_START; // R1 R2
			end
			scp_pkg::SCP_UX_START: begin
				if (rcnt_r == HALF) begin
					rcnt_nxt = 8'h00;
					rbit_nxt = 3'h0;
					rs_nxt = rxd_r ? scp_pkg::SCP_UX_IDLE : scp_pkg::SCP_UX_DATA;
				end
			end
			scp_pkg::SCP_UX_DATA: begin
				if (rcnt_r == FULL) begin
					rcnt_nxt = 8'h00;
					rsh_nxt = {rxd_r, rsh_r[7:1]}; // lsb first R1
					rbit_nxt = rbit_r + 3'h1;
					if (rbit_r == 3'h7) rs_nxt = scp_pkg::SCP_UX_STOP;
				end
			end
			scp_pkg::SCP_UX_STOP: begin
				if (rcnt_r == FULL) begin
					rs_nxt = scp_pkg::SCP_UX_IDLE;
					rstb_nxt = rxd_r; // framing error drops the byte R1
				end
			end
			default: rs_nxt = scp_pkg::SCP_UX_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			rs_r <= scp_pkg::SCP_UX_IDLE;
			rcnt_r <= 8'h00;
			rsh_r <= 8'h00;
			rbit_r <= 3'h0;
			rstb_r <= 1'b0;
		end else begin
			rs_r <= rs_nxt;
			rcnt_r <= rcnt_nxt;
			rsh_r <= rsh_nxt;
			rbit_r <= rbit_nxt;
			rstb_r <= rstb_nxt;
		end
	end
	// ==========================================================
	// shared command/reply buffer and exchange sequencer
	logic [7:0] buf_mem [`SCP_BUF_DEPTH]; // R9
	scp_pkg::scp_state_type st_r, st_nxt;
	logic [`SCP_BUF_AW:0] wp_r, wp_nxt, rp_r, rp_nxt, len_r, len_nxt;
	logic [7:0] last_r, last_nxt; // previous terminator, 0 when none
	logic tstb, tx_busy, cv_nxt, busy_nxt, bwe; // tstb: transmitter byte request
	logic [7:0] tbyte;
	logic [1:0] tix_r, tix_nxt; // terminator index, 2 once line feed is passed to the transmitter
	logic err_r, err_nxt;
	logic [7:0] ecode_r, ecode_nxt;
	logic [`SCP_BUF_AW-1:0] bwa;
	logic [7:0] bwd;
	always_comb begin
		st_nxt = st_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		len_nxt = len_r;
		last_nxt = last_r;
		tix_nxt = tix_r;
		err_nxt = err_r;
		ecode_nxt = ecode_r;
		tstb = 1'b0;
		tbyte = `SCP_CH_CR;
		bwe = 1'b0;
		bwa = wp_r[`SCP_BUF_AW-1:0];
		bwd = scp_upper(rsh_r); // R4
		case (st_r)
			scp_pkg::SCP_IDLE, scp_pkg::SCP_RECV: begin
				if (rstb_r) begin
					if (scp_is_term(rsh_r)) begin
						// pair partner of previous terminator is swallowed R16
						if (last_r != 8'h00 && rsh_r != last_r && wp_r == '0) begin
							last_nxt = 8'h00;
						end else begin
							last_nxt = rsh_r;
							st_nxt = scp_pkg::SCP_EXEC; // R6
						end
					end else begin
						last_nxt = 8'h00;
						st_nxt = scp_pkg::SCP_RECV;
						if (wp_r != (`SCP_BUF_AW+1)'(`SCP_BUF_DEPTH)) begin
							bwe = 1'b1;
							wp_nxt = wp_r + 1'b1;
						end
					end
				end
			end
			scp_pkg::SCP_EXEC: begin
				if (proc_we) begin
					bwe = 1'b1; // reply overwrites command in place R9
					bwa = proc_addr;
					bwd = proc_wdata;
				end
				if (proc_done) begin
					len_nxt = proc_error ? '0 : reply_len; // R14
					err_nxt = proc_error; // R15
					ecode_nxt = err_code;
					rp_nxt = '0;
					tix_nxt = 2'd0;
					st_nxt = scp_pkg::SCP_SEND; // R7
				end
			end
			scp_pkg::SCP_SEND: begin
				if (!tx_busy) begin
					if (err_r) begin
						tstb = 1'b1;
						tbyte = ecode_r; // R15
						err_nxt = 1'b0;
					end else if (rp_r != len_r) begin
						tstb = 1'b1;
						tbyte = buf_mem[rp_r[`SCP_BUF_AW-1:0]];
						rp_nxt = rp_r + 1'b1;
					end else begin
						st_nxt = scp_pkg::SCP_TERM;
					end
				end
			end
			scp_pkg::SCP_TERM: begin
				// stay busy until the line feed has left the line R5
				if (!tx_busy && tix_r == 2'd2) begin
					wp_nxt = '0;
					st_nxt = scp_pkg::SCP_IDLE;
				end else if (!tx_busy) begin
					tstb = 1'b1;
					tbyte = (tix_r == 2'd0) ? `SCP_CH_CR : `SCP_CH_LF; // R5
					tix_nxt = tix_r + 2'd1;
				end
			end
			default: st_nxt = scp_pkg::SCP_IDLE;
		endcase
		cv_nxt = (st_r != scp_pkg::SCP_EXEC) && (st_nxt == scp_pkg::SCP_EXEC); // R13
		busy_nxt = (st_nxt == scp_pkg::SCP_EXEC) || (st_nxt == scp_pkg::SCP_SEND)
			|| (st_nxt == scp_pkg::SCP_TERM);
	end
	always_ff @(posedge clk) begin
		if (bwe) buf_mem[bwa] <= bwd;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= scp_pkg::SCP_IDLE;
			wp_r <= '0;
			rp_r <= '0;
			len_r <= '0;
			last_r <= 8'h00;
			tix_r <= 2'd0;
			err_r <= 1'b0;
			ecode_r <= 8'h00;
			cmd_valid <= 1'b0;
			cmd_len <= '0;
			busy <= 1'b0;
			proc_rdata <= 8'h00;
		end else begin
			st_r <= st_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			len_r <= len_nxt;
			last_r <= last_nxt;
			tix_r <= tix_nxt;
			err_r <= err_nxt;
			ecode_r <= ecode_nxt;
			cmd_valid <= cv_nxt;
			cmd_len <= wp_nxt;
			busy <= busy_nxt;
			proc_rdata <= buf_mem[proc_addr];
		end
	end
	// ==========================================================
	// transmitter: start, 8 data lsb first, one stop; drives the DCE send line
	logic [9:0] tsh_r, tsh_nxt;
	logic [3:0] tn_r, tn_nxt;
	logic [7:0] tcnt_r, tcnt_nxt;
	logic txo_nxt;
	always_comb begin
		tsh_nxt = tsh_r;
		tn_nxt = tn_r;
		tcnt_nxt = tcnt_r;
		txo_nxt = tx_line;
		if (tn_r == 4'h0) begin
			txo_nxt = 1'b1;
			if (tstb) begin
				tsh_nxt = {1'b1, tbyte, 1'b0}; // R1
				tn_nxt = 4'(`SCP_DATA_BITS + `SCP_STOP_BITS + 1);
				tcnt_nxt = 8'h00;
			end
		end else if (tcnt_r == 8'h00) begin
			txo_nxt = tsh_r[0]; // R3
			tsh_nxt = {1'b1, tsh_r[9:1]};
			tcnt_nxt = FULL;
		end else begin
			tcnt_nxt = tcnt_r - 8'h01;
			if (tcnt_r == 8'h01) tn_nxt = tn_r - 4'h1;
		end
	end
	assign tx_busy = (tn_r != 4'h0);
	always_ff @(posedge clk) begin
		if (reset) begin
			tsh_r <= 10'h3FF;
			tn_r <= 4'h0;
			tcnt_r <= 8'h00;
			tx_line <= 1'b1;
		end else begin
			tsh_r <= tsh_nxt;
			tn_r <= tn_nxt;
			tcnt_r <= tcnt_nxt;
			tx_line <= txo_nxt;
		end
	end
	// ==========================================================
	// separate network-side reply buffer, independent of the serial path
	logic [7:0] nbuf [`SCP_OUT_DEPTH]; // R10 R12
	logic [`SCP_OUT_AW:0] nw_r, nw_nxt, nr_r, nr_nxt;
	logic nv_nxt, npop;
	logic [7:0] nd_nxt;
	always_comb begin
		npop = net_rd_valid && net_rd_ready;
		nr_nxt = nr_r;
		nv_nxt = net_rd_valid && !net_rd_ready;
		nd_nxt = net_rd_data;
		if ((!net_rd_valid || npop) && (nr_r != nw_r)) begin
			nd_nxt = nbuf[nr_r[`SCP_OUT_AW-1:0]];
			nv_nxt = 1'b1;
			nr_nxt = nr_r + 1'b1;
		end
		nw_nxt = nw_r;
		if (net_wr_valid && ((nw_r - nr_r) != (`SCP_OUT_AW+1)'(`SCP_OUT_DEPTH))) begin
			nw_nxt = nw_r + 1'b1; // full buffer drops the write
		end
	end
	always_ff @(posedge clk) begin
		if (nw_nxt != nw_r) nbuf[nw_r[`SCP_OUT_AW-1:0]] <= net_wr_data;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			nw_r <= '0;
			nr_r <= '0;
			net_rd_valid <= 1'b0;
			net_rd_data <= 8'h00;
		end else begin
			nw_r <= nw_nxt;
			nr_r <= nr_nxt;
			net_rd_valid <= nv_nxt;
			net_rd_data <= nd_nxt;
		end
	end
endmodule : scp_serial_command_port
`default_nettype wire

// ---- tb/scp_asserts.sv ----
// concurrent checks on the serial command port pins
`default_nettype none
`include "scp_params.svh"
module scp_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic tx_line,
	input wire logic cmd_valid,
	input wire logic [`SCP_BUF_AW:0] cmd_len,
	input wire logic busy,
	input wire logic net_rd_valid,
	input wire logic net_rd_ready,
	input wire logic [7:0] net_rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	// =====
	// pin relations
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rst;
		$fell(reset) |-> tx_line && !busy && !cmd_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_start;
		$fell(tx_line) |-> (!tx_line && busy) [*8];
	endproperty
	a_start: assert property (p_start) else $error("start bit glitch or no reply");
	property p_bit;
		$fell(tx_line) |-> ##173 !tx_line;
	endproperty
	a_bit: assert property (p_bit) else $error("start bit too short");
	property p_quiet;
		!busy && $past(!busy) |-> tx_line;
	endproperty
	a_quiet: assert property (p_quiet) else $error("line active with no reply");
	property p_cv1;
		cmd_valid |=> !cmd_valid;
	endproperty
	a_cv1: assert property (p_cv1) else $error("command pulse too long");
	property p_cvb;
		cmd_valid |=> busy [*8];
	endproperty
	a_cvb: assert property (p_cvb) else $error("not busy on command");
	property p_len;
		cmd_valid |-> cmd_len <= 6'h20;
	endproperty
	a_len: assert property (p_len) else $error("command longer than buffer");
	property p_hold;
		net_rd_valid && !net_rd_ready |=> net_rd_valid && $stable(net_rd_data);
	endproperty
	a_hold: assert property (p_hold) else $error("network data dropped");
	c_cmd: cover property (cmd_valid);
	c_end: cover property ($fell(busy));
	c_net: cover property (net_rd_valid && net_rd_ready);
endmodule : scp_asserts
`default_nettype wire

// ---- tb/scp_host.sv ----
// host terminal model: 8N1 sender and receiver, no handshake lines
`default_nettype none
`include "scp_params.svh"
module scp_host (
	input wire logic clk,
	output var logic to_dev,
	input wire logic from_dev
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BT = `SCP_BIT_CYC;
	logic [7:0] got[$];
	// =====
	// idle high, lsb first, one stop bit
	initial to_dev = 1'b1;
	task automatic put(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			to_dev <= f[i];
			repeat (BT) @(posedge clk);
			#1;
		end
	endtask : put
	// sample each bit at its centre, keep framed bytes
	always begin : rcv
		logic [7:0] b;
		@(negedge from_dev);
		repeat (BT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BT) @(posedge clk);
			b[i] = from_dev;
		end
		repeat (BT) @(posedge clk);
		if (from_dev === 1'b1) got.push_back(b);
	end
endmodule : scp_host
`default_nettype wire

// ---- tb/test_serial_command_port.sv ----
// testbench: host model on the line, bench acts as command processor
`default_nettype none
`include "scp_params.svh"
module test_serial_command_port;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BT = `SCP_BIT_CYC;
	logic clk, reset, rx_line, tx_line, cmd_valid, proc_we, proc_done, proc_error, busy;
	logic [`SCP_BUF_AW:0] cmd_len, reply_len;
	logic [`SCP_BUF_AW-1:0] proc_addr;
	logic [7:0] proc_rdata, proc_wdata, err_code, net_wr_data, net_rd_data;
	logic net_wr_valid, net_rd_ready, net_rd_valid;
	int errors = 0, checks = 0, ncv = 0;
	scp_serial_command_port dut (.*);
	scp_host host (.clk(clk), .to_dev(rx_line), .from_dev(tx_line));
	// =====
	// clock and command pulse count
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (cmd_valid === 1'b1) ncv <= ncv + 1;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) host.put(s[i]);
		tick(BT);
	endtask : send
	// write reply byte, finish, then compare what the host got
	task automatic reply(input logic [7:0] b, input int n, input logic er, input string x);
		proc_we = 1'b1;
		proc_addr = '0;
		proc_wdata = b;
		tick(1);
		proc_we = 1'b0;
		proc_done = 1'b1;
		reply_len = 6'(n);
		proc_error = er;
		err_code = b;
		tick(1);
		proc_done = 1'b0;
		proc_error = 1'b0;
		for (int i = 0; i < 40 * BT && busy !== 1'b0; i++) tick(1);
		chk({7'h00, busy}, 8'h00);
		tick(2 * BT);
		chk(8'(host.got.size()), 8'(x.len()));
		for (int i = 0; i < x.len() && i < host.got.size(); i++) chk(host.got[i], x[i]);
		host.got.delete();
	endtask : reply
	task automatic t_plain;
		send("a\015");
		chk(8'(ncv), 8'h01);
		chk({2'b00, cmd_len}, 8'h01);
		proc_addr = '0;
		tick(2);
		chk(proc_rdata, 8'h41);
		reply(8'h5a, 1, 1'b0, "Z\015\012");
		$display("plain command done");
	endtask : t_plain
	task automatic t_pair;
		send("b\012\015");
		chk(8'(ncv), 8'h02);
		reply(8'h00, 0, 1'b0, "\015\012");
		chk(8'(ncv), 8'h02);
		$display("terminator pair done");
	endtask : t_pair
	task automatic t_err;
		send("q\012");
		chk(8'(ncv), 8'h03);
		reply(8'h3f, 0, 1'b1, "?\015\012");
		$display("error reply done");
	endtask : t_err
	task automatic t_net;
		for (int i = 0; i < 3; i++) begin
			net_wr_valid = 1'b1;
			net_wr_data = 8'h61 + 8'(i);
			tick(1);
		end
		net_wr_valid = 1'b0;
		tick(3);
		for (int i = 0; i < 3; i++) begin
			chk({7'h00, net_rd_valid}, 8'h01);
			chk(net_rd_data, 8'h61 + 8'(i));
			net_rd_ready = 1'b1;
			tick(1);
			net_rd_ready = 1'b0;
			tick(2);
		end
		chk({7'h00, net_rd_valid}, 8'h00);
		$display("network buffer done");
	endtask : t_net
	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// main sequence, serial and network side by side
	initial begin
		reset = 1'b1;
		{proc_we, proc_done, proc_error, net_wr_valid, net_rd_ready} = '0;
		{proc_addr, proc_wdata, reply_len, err_code, net_wr_data} = '0;
		tick(4);
		reset = 1'b0;
		tick(1);
		fork
			t_plain();
			t_net();
		join
		t_pair();
		t_err();
		close_out();
	end
	// watchdog against a hung reply
	initial begin
		tick(60000);
		errors++;
		close_out();
	end
endmodule : test_serial_command_port
bind scp_serial_command_port scp_asserts u_chk (.*);
`default_nettype wire
